// ---- bench/host_model.sv ----
// Behavioural host that makes register accesses.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   // Clock.
   input wire logic clk,
   // Requests.
   output logic [7:0] reg_addr = 8'h00,
   output logic reg_wr_en = 1'b0,
   output logic [7:0] reg_wr_data = 8'h00,
   output logic reg_rd_en = 1'b0,
   // Answers.
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid,
   input wire logic reg_wr_refused
);
   // One access: driven on a falling edge, taken on the next rising edge, and
   // answered on the following falling edge while the one-cycle pulse stands.
   // partner address is changed before the owner address by callers.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic s);
      @(negedge clk);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = w;
      reg_rd_en = !w;
      @(negedge clk);
      // The answer is taken before anything is released.
      q = reg_rd_data;
      s = w ? reg_wr_refused : reg_rd_valid;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      // Released lines show a changed value so stale data cannot pass.
      reg_addr = ~a;
      reg_wr_data = ~d;
   endtask
endmodule
`default_nettype wire

// ---- bench/link_config_props.sv ----
// Checker for the configuration register bank ports.
`timescale 1ns/1ps
`default_nettype none
module link_config_props
(
   // Clock and resets.
   input wire logic clk,
   input wire logic rst,
   input wire logic power_down_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid,
   input wire logic reg_wr_refused,
   // Configuration outputs.
   input wire logic [6:0] own_bus_address,
   input wire logic write_lock,
   input wire logic [6:0] partner_bus_address,
   input wire logic [2:0] spread_select,
   input wire logic spread_active,
   input wire logic audio_channel_enable,
   input wire logic [1:0] pixel_clock_range,
   input wire logic pixel_range_auto,
   input wire logic [1:0] serial_rate_range,
   input wire logic serial_rate_auto
);
   // Both reset sources stop every check.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst || !power_down_n);
   property p_own;
      !write_lock && reg_wr_en && reg_addr == 8'h00 |=>
         {own_bus_address, write_lock} == $past(reg_wr_data);
   endproperty
   a_own: assert property (p_own) else $error("own address write lost");
   // Partner address lands with the reserved low bit forced to zero.
   property p_partner;
      !write_lock && reg_wr_en && reg_addr == 8'h01 |=>
         {partner_bus_address, 1'b0} == ($past(reg_wr_data) & 8'hFE);
   endproperty
   a_partner: assert property (p_partner) else $error("partner address write lost");
   property p_lock;
      write_lock && reg_wr_en && reg_addr <= 8'h1F |=>
         reg_wr_refused && $stable(spread_select) && $stable(own_bus_address);
   endproperty
   a_lock: assert property (p_lock) else $error("locked write not refused");
   property p_hold;
      write_lock |=> write_lock;
   endproperty
   a_hold: assert property (p_hold) else $error("lock dropped");
   property p_rsv;
      reg_rd_en && reg_addr == 8'h01 |=> reg_rd_data[0] == 1'b0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_spa;
      spread_active == (spread_select[1:0] != 2'h0);
   endproperty
   a_spa: assert property (p_spa) else $error("spread flag wrong");
   property p_cfg;
      !write_lock && reg_wr_en && reg_addr == 8'h02 |=> {spread_select, audio_channel_enable,
         pixel_clock_range, serial_rate_range} == $past(reg_wr_data);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config write lost");
   property p_auto;
      pixel_range_auto == (pixel_clock_range == 2'h3) &&
         serial_rate_auto == (serial_rate_range == 2'h3);
   endproperty
   a_auto: assert property (p_auto) else $error("auto flag wrong");
   property p_rd;
      reg_rd_en |=> reg_rd_valid;
   endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   // Main scenarios.
   c_refuse: cover property (reg_wr_refused);
   c_read: cover property (reg_rd_valid && reg_rd_data != 8'h00);
   c_lock: cover property ($rose(write_lock));
endmodule
bind serializer_link_config_regs link_config_props i_link_config_props (.*);
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
   logic clk = 0, rst = 1, power_down_n = 1, spread_enable_pin = 1;
   logic [1:0] address_select_pin_a = 2'h2, address_select_pin_b = 2'h1;
   wire [7:0] reg_addr, reg_wr_data, reg_rd_data;
   wire reg_wr_en, reg_rd_en, reg_rd_valid, reg_wr_refused, write_lock, spread_active;
   wire audio_channel_enable, pixel_range_auto, serial_rate_auto;
   wire [6:0] own_bus_address, partner_bus_address;
   wire [2:0] spread_select;
   wire [1:0] pixel_clock_range, serial_rate_range;
   int error_cnt = 0, total_checks = 0;
   logic [7:0] a, d, e, q;
   logic f;
   // Rows: offset, write data, expected read back.
   logic [23:0] rows [11] = '{24'h020000, 24'h023535, 24'h024A4A, 24'h027F7F,
      24'h028080, 24'h02B5B5, 24'h02CACA, 24'h02EFEF, 24'h01ABAA, 24'h055A00, 24'h004242};
   serializer_link_config_regs i_serializer_link_config_regs (.*);
   host_model i_host_model (.*);
   initial forever #2.5 clk = ~clk;
   // Reads the three mapped registers against expected values.
   task automatic chk3(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
      i_host_model.xfer(1'b0, 8'h00, 8'h00, q, f);
      `CHK("reg0", e0, q)
      i_host_model.xfer(1'b0, 8'h01, 8'h00, q, f);
      `CHK("reg1", e1, q)
      i_host_model.xfer(1'b0, 8'h02, 8'h00, q, f);
      `CHK("reg2", e2, q)
   endtask
   task results;
      $display("Checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge clk);
      rst = 0;
      chk3(8'h84, 8'h94, 8'h3F);
      `CHK("straps", {7'h42, 7'h4A}, {own_bus_address, partner_bus_address})
      `CHK("spread on", 1'b1, spread_active)
      `CHK("autos", 2'h3, {pixel_range_auto, serial_rate_auto})
      for (int i = 0; i < 11; i++)
      begin
         {a, d, e} = rows[i];
         i_host_model.xfer(1'b1, a, d, q, f);
         `CHK("refused", 1'b0, f)
         i_host_model.xfer(1'b0, a, 8'h00, q, f);
         `CHK("valid", 1'b1, f)
         `CHK("read", e, q)
         if (a == 8'h00)
         begin
            `CHK("own word", d, {own_bus_address, write_lock})
         end
         if (a == 8'h01)
         begin
            `CHK("partner", d[7:1], partner_bus_address)
         end
         if (a == 8'h02)
         begin
            `CHK("active", d[6:5] != 2'h0, spread_active)
            `CHK("spread", d[7:5], spread_select)
            `CHK("audio", d[4], audio_channel_enable)
            `CHK("ranges", d[3:0], {pixel_clock_range, serial_rate_range})
            `CHK("pixel auto", d[3:2] == 2'h3, pixel_range_auto)
            `CHK("rate auto", d[1:0] == 2'h3, serial_rate_auto)
         end
      end
      // Lock with a new address, then writes at, inside and past the locked span.
      i_host_model.xfer(1'b1, 8'h00, 8'h43, q, f);
      `CHK("own", 7'h21, own_bus_address)
      `CHK("lock", 1'b1, write_lock)
      for (int i = 0; i < 3; i++)
      begin
         a = (i == 0) ? 8'h02 : ((i == 1) ? 8'h1F : 8'h20);
         i_host_model.xfer(1'b1, a, 8'h00, q, f);
         `CHK("refused", a != 8'h20, f)
      end
      chk3(8'h43, 8'hAA, 8'hEF);
      // Power-down clears the lock and reloads other strap values.
      spread_enable_pin = 0;
      address_select_pin_a = 2'h3;
      address_select_pin_b = 2'h0;
      power_down_n = 0;
      repeat (2) @(negedge clk);
      power_down_n = 1;
      `CHK("unlock", 1'b0, write_lock)
      `CHK("pd straps", {7'h00, 7'h08}, {own_bus_address, partner_bus_address})
      `CHK("spread off", 1'b0, spread_active)
      chk3(8'h00, 8'h10, 8'h1F);
      results;
   end
endmodule
`default_nettype wire

// ---- core/address_strap_decode.sv ----
// Turns the two three-level address-select pins into default bus addresses.
`timescale 1ns/1ps
`default_nettype none

module address_strap_decode
(
   // Three-level pin levels.
   input wire logic [1:0] address_select_pin_a,
   input wire logic [1:0] address_select_pin_b,
   // Default seven-bit addresses.
   output logic [6:0] own_default,
   output logic [6:0] partner_default
);
   import link_config_pkg::*;

   // Each pin contributes two address bits; an illegal code falls back to low.
   function automatic logic [1:0] strap_bits(input logic [1:0] code);
      logic [1:0] bits;
      bits = 2'h0;
      unique case (code)
         TRI_LOW:
         begin
            bits = 2'h0;
         end
         TRI_OPEN:
         begin
            bits = 2'h1;
         end
         TRI_HIGH:
         begin
            bits = 2'h2;
         end
         default:
         begin
            bits = 2'h0;
         end
      endcase
      return bits;
   endfunction

   // Both defaults share the pin bits and differ only in the middle pair.
   always_comb
   begin
      own_default = {strap_bits(address_select_pin_a), OWN_ADDRESS_MIDDLE,
                     strap_bits(address_select_pin_b), ADDRESS_LOW_BIT};
      partner_default = {strap_bits(address_select_pin_a), PARTNER_ADDRESS_MIDDLE,
                         strap_bits(address_select_pin_b), ADDRESS_LOW_BIT};
   end

endmodule

`default_nettype wire

// ---- core/link_config_pkg.sv ----
// Shared constants and types for the serializer link configuration register bank.
package link_config_pkg;

   // Register offsets on the control channel.
   localparam logic [7:0] OFFSET_OWN_ADDRESS = 8'h00;
   localparam logic [7:0] OFFSET_PARTNER_ADDRESS = 8'h01;
   localparam logic [7:0] OFFSET_SPREAD_AUDIO_RATE = 8'h02;
   // Highest offset covered by the write lock.
   localparam logic [7:0] OFFSET_LOCK_LAST = 8'h1F;

   // Field positions inside the registers.
   localparam int LOCK_BIT = 0;
   localparam int ADDRESS_MSB = 7;
   localparam int ADDRESS_LSB = 1;
   localparam int RESERVED_BIT = 0;
   localparam int SPREAD_MSB = 7;
   localparam int SPREAD_LSB = 5;
   localparam int AUDIO_BIT = 4;
   localparam int PIXEL_MSB = 3;
   localparam int PIXEL_LSB = 2;
   localparam int RATE_MSB = 1;
   localparam int RATE_LSB = 0;

   // Reset values.
   localparam logic LOCK_RESET = 1'b0;
   localparam logic RESERVED_RESET = 1'b0;
   localparam logic [2:0] SPREAD_RESET_PIN_LOW = 3'h0;
   localparam logic [2:0] SPREAD_RESET_PIN_HIGH = 3'h1;
   localparam logic AUDIO_RESET = 1'b1;
   localparam logic [1:0] RANGE_AUTOMATIC = 2'h3;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Spread codes that mean no spreading at all.
   localparam logic [2:0] SPREAD_NONE_A = 3'h0;
   localparam logic [2:0] SPREAD_NONE_B = 3'h4;

   // Fixed middle bits of the strap-derived default addresses.
   localparam logic [1:0] OWN_ADDRESS_MIDDLE = 2'h0;
   localparam logic [1:0] PARTNER_ADDRESS_MIDDLE = 2'h1;
   localparam logic ADDRESS_LOW_BIT = 1'b0;

   // Level seen on a three-level address-select pin.
   typedef enum logic [1:0]
   {
      TRI_LOW = 2'b00,
      TRI_OPEN = 2'b01,
      TRI_HIGH = 2'b10
   } tri_level_e;

endpackage

// ---- core/serializer_link_config_regs.sv ----
// Configuration register bank of the serializer, reached from the control channel.
//
// Operation
// - Own address in 0x00, strapped default.
// - Lock bit makes 0x00..0x1F read only.
// - Lock holds until reset or power-down.
// - Partner address in 0x01, reserved bit zero.
// - Spread select field, pin-chosen default.
// - Pixel clock range field, resets automatic.
// - Serial rate range field, resets automatic.
`timescale 1ns/1ps
`default_nettype none

module serializer_link_config_regs
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Configuration pins.
   input wire logic power_down_n,
   input wire logic spread_enable_pin,
   input wire logic [1:0] address_select_pin_a,
   input wire logic [1:0] address_select_pin_b,
   // Register access from the control channel.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data,
   output logic reg_rd_valid,
   output logic reg_wr_refused,
   // Configuration presented to the rest of the serializer.
   output logic [6:0] own_bus_address,
   output logic write_lock,
   output logic [6:0] partner_bus_address,
   output logic [2:0] spread_select,
   output logic spread_active,
   output logic audio_channel_enable,
   output logic [1:0] pixel_clock_range,
   output logic pixel_range_auto,
   output logic [1:0] serial_rate_range,
   output logic serial_rate_auto
);
   import link_config_pkg::*;

   // Every piece of state of the bank lives in this one record.
   typedef struct packed
   {
      // Stored register words, one for each mapped offset.
      logic [7:0] own_word;
      logic [7:0] partner_word;
      logic [7:0] config_word;
      // Read answer and the one-cycle access pulses.
      logic [7:0] rd_data;
      logic rd_valid;
      logic wr_refused;
      // Decoded flags, kept in flip-flops so the outputs need no gates of their own.
      logic spread_active;
      logic pixel_auto;
      logic rate_auto;
   } state_s;

   // Registered state and its next value.
   state_s state_reg;
   state_s state_next;

   // Strap-derived default addresses.
   logic [6:0] own_default;
   logic [6:0] partner_default;

   // Reset is either the system reset or the power-down pin held low.
   logic bank_reset;

   // Write lock as currently stored.
   logic locked;

   // True when an access falls in the range the lock protects.
   // Offset zero is the bottom of the span, so only the top needs a compare.
   function automatic logic in_lock_range(input logic [7:0] addr);
      return addr <= OFFSET_LOCK_LAST;
   endfunction

   // Readback value of a register; unmapped offsets read as zero.
   function automatic logic [7:0] read_word(input state_s s, input logic [7:0] addr);
      logic [7:0] word;
      word = READ_UNMAPPED;
      // Three registers do not justify a table; each offset is compared in turn.
      if (addr == OFFSET_OWN_ADDRESS)
      begin
         word = s.own_word;
      end
      else if (addr == OFFSET_PARTNER_ADDRESS)
      begin
         word = s.partner_word;
      end
      else if (addr == OFFSET_SPREAD_AUDIO_RATE)
      begin
         word = s.config_word;
      end
      return word;
   endfunction

   // The strap decode is pure logic; it is only sampled while reset is applied.
   address_strap_decode u_strap
   (
      .address_select_pin_a(address_select_pin_a),
      .address_select_pin_b(address_select_pin_b),
      .own_default(own_default),
      .partner_default(partner_default)
   );

   // The lock is the low bit of the own-address word, so one write sets both.
   assign locked = state_reg.own_word[LOCK_BIT];

   // Both sources act on the clock edge; the pin is taken as synchronous to clk.
   // power-down reset
   assign bank_reset = rst || !power_down_n;

   // Next-state logic: reset loads, then writes, then reads, then derived flags.
   always_comb
   begin
      state_next = state_reg;
      state_next.rd_valid = 1'b0;
      state_next.wr_refused = 1'b0;
      // Straps are sampled only here; moving a pin later waits for the next reset.
      if (bank_reset)
      begin
         state_next.own_word = {own_default, LOCK_RESET};
         state_next.partner_word = {partner_default, RESERVED_RESET};
         state_next.config_word[SPREAD_MSB:SPREAD_LSB] =
            spread_enable_pin ? SPREAD_RESET_PIN_HIGH : SPREAD_RESET_PIN_LOW;
         state_next.config_word[AUDIO_BIT] = AUDIO_RESET;
         state_next.config_word[PIXEL_MSB:PIXEL_LSB] = RANGE_AUTOMATIC;
         state_next.config_word[RATE_MSB:RATE_LSB] = RANGE_AUTOMATIC;
         // Clear the read data so nothing read before reset can leak out after it.
         state_next.rd_data = READ_UNMAPPED;
      end
      else
      begin
         // A refused write is dropped whole; the pulse tells the host it was lost.
         // lock blocks writes
         if (reg_wr_en && locked && in_lock_range(reg_addr))
         begin
            state_next.wr_refused = 1'b1;
         end
         else if (reg_wr_en)
         begin
            // Unmapped offsets fall through every branch and are ignored silently.
            // The lock bit is written with the address, so setting it is one write.
            if (reg_addr == OFFSET_OWN_ADDRESS)
            begin
               // Address and lock are replaced together.
               // own address written
               state_next.own_word = reg_wr_data;
            end
            else if (reg_addr == OFFSET_PARTNER_ADDRESS)
            begin
               // Only the address bits are taken from the write.
               // reserved bit kept zero
               state_next.partner_word = {reg_wr_data[ADDRESS_MSB:ADDRESS_LSB],
                                          RESERVED_RESET};
            end
            else if (reg_addr == OFFSET_SPREAD_AUDIO_RATE)
            begin
               // Every code of every field is legal, so the whole word is taken.
               // spread, audio, ranges written
               state_next.config_word = reg_wr_data;
            end
         end
         // The read sees the stored value, so a same-cycle write shows only later.
         // reads work when locked
         if (reg_rd_en)
         begin
            state_next.rd_data = read_word(state_reg, reg_addr);
            state_next.rd_valid = 1'b1;
         end
      end
      // Derived flags follow the register they describe in the same cycle.
      // Registering them costs three flip-flops but keeps every output glitch free.
      state_next.spread_active =
         (state_next.config_word[SPREAD_MSB:SPREAD_LSB] != SPREAD_NONE_A) &&
         (state_next.config_word[SPREAD_MSB:SPREAD_LSB] != SPREAD_NONE_B);
      state_next.pixel_auto =
         state_next.config_word[PIXEL_MSB:PIXEL_LSB] == RANGE_AUTOMATIC;
      state_next.rate_auto =
         state_next.config_word[RATE_MSB:RATE_LSB] == RANGE_AUTOMATIC;
   end

   // Keeping reset out of this process leaves one plain register for the record.
   // One register stage for the whole record; reset is handled in the next-state logic.
   always_ff @(posedge clk)
   begin
      state_reg <= state_next;
   end

   // Outputs are plain slices of the registered record.
   // No gate sits between the record and a pin, so every output is a flip-flop.
   assign reg_rd_data = state_reg.rd_data;
   assign reg_rd_valid = state_reg.rd_valid;
   assign reg_wr_refused = state_reg.wr_refused;
   assign own_bus_address = state_reg.own_word[ADDRESS_MSB:ADDRESS_LSB];
   assign write_lock = state_reg.own_word[LOCK_BIT];
   assign partner_bus_address = state_reg.partner_word[ADDRESS_MSB:ADDRESS_LSB];
   assign spread_select = state_reg.config_word[SPREAD_MSB:SPREAD_LSB];
   assign spread_active = state_reg.spread_active;
   assign audio_channel_enable = state_reg.config_word[AUDIO_BIT];
   assign pixel_clock_range = state_reg.config_word[PIXEL_MSB:PIXEL_LSB];
   assign pixel_range_auto = state_reg.pixel_auto;
   assign serial_rate_range = state_reg.config_word[RATE_MSB:RATE_LSB];
   assign serial_rate_auto = state_reg.rate_auto;

endmodule

`default_nettype wire
